// file: xsp_defines.svh
/*
  Constants of the external serial port transfer engine: selector codes,
  chip-select actions, reset values and timing counts.
  Assumes a 125 MHz core clock; included by its bare name.
*/
`ifndef XSP_DEFINES_SVH
`define XSP_DEFINES_SVH

// --------------------------------------------------------------------------
// selector and field codes
// --------------------------------------------------------------------------
`define XSP_SEL_ZERO      16'h0000
`define XSP_SEL_ONES      16'hffff
`define XSP_CS_NONE       16'h0000
`define XSP_CS_FALL       16'h0001
`define XSP_CS_RISE       16'h0002
`define XSP_HS_ON         16'h0001
`define XSP_BYTES_MAX     3'h4
`define XSP_CS_RESET      1'b1

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define XSP_CLK_PERIOD_NS 8
`define XSP_CS_PULSE_NS   160
`define XSP_CS_PULSE_CYC  ((`XSP_CS_PULSE_NS + `XSP_CLK_PERIOD_NS - 1) / `XSP_CLK_PERIOD_NS)

`endif

// file: xsp_pkg.sv
/*
  Types of the external serial port transfer engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package xsp_pkg;

  // command as issued by the host, all fields 16-bit words, ops a signed count
  typedef struct packed {
    logic [15:0] ops;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] nbytes;
    logic [15:0] cs_mode;
    logic [15:0] hs;
  } xsp_cmd_t;

  // one received word on its way to the register file
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] data;
  } xsp_wr_t;

  typedef enum logic [2:0] {
    XSP_IDLE, XSP_CSP, XSP_HS, XSP_FETCH, XSP_LOAD, XSP_ALIGN, XSP_SHIFT, XSP_STORE
  } xsp_phase_t;

  typedef struct packed {
    xsp_phase_t  ph;
    logic [15:0] left;
    logic [15:0] src;
    logic [15:0] dst;
    logic [2:0]  nb;
    logic        inc;
    logic        hs;
    logic [31:0] sh;
    logic [31:0] rx;
    logic [5:0]  bits;
    logic [7:0]  cnt;
    logic        cs;
    logic        sck;
    logic        mosi;
    logic        busy;
    logic        rd_en;
    logic        push;
    logic [2:0]  lk;
    logic [1:0]  mi;
    logic        rdy;
  } xsp_core_t;

endpackage : xsp_pkg

// file: xsp_skid2.sv
/*
  Two-entry buffer with valid and ready on both sides; out_data and out_valid are flops, in_ready is the inverted tail valid flop.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module xsp_skid2 #(
  parameter int W = 48
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic         hv;
    logic         tv;
  } xsp_skid_t;

  xsp_skid_t s_reg;
  xsp_skid_t s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.hv && out_ready) begin
      s_next.head = s_reg.tail;
      s_next.hv   = s_reg.tv;
      s_next.tv   = 1'b0;
    end
    if (in_valid && !s_reg.tv) begin
      if (!s_next.hv) begin
        s_next.head = in_data;
        s_next.hv   = 1'b1;
      end else begin
        s_next.tail = in_data;
        s_next.tv   = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = !s_reg.tv;
  assign out_data  = s_reg.head;
  assign out_valid = s_reg.hv;

endmodule : xsp_skid2

// file: xsp_engine.sv
/*
  Background transfer engine of the external serial port: master side.
  Assumes a register file with one-cycle read latency on rd_idx/rd_data,
  a write port that may stall, and a shift clock from the mode setup logic.
*/
// Behaviour
// - run as many cycles as the magnitude of the signed count
// - negative count also steps a register index after every cycle
// - step source index, or destination when source is 0 or -1
// - source 0 sends zero bytes, source -1 sends all-one bytes
// - received word goes to destination; destination 0 discards it
// - one to four bytes per register, least significant ones used
// - most significant byte first out and in
// - chip select action 0 none, 1 pulse high then low, 2 inverse
// - handshake 1 waits for low data input before every cycle
// - each command may repeat the chip select pulse
// - outgoing data fetched from source register
`timescale 1ns/1ps
`include "xsp_defines.svh"
module xsp_engine (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire xsp_pkg::xsp_cmd_t cmd,
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  output logic                 busy,
  output logic                 rd_en,
  output logic [15:0]          rd_idx,
  input  wire logic [31:0]     rd_data,
  output xsp_pkg::xsp_wr_t     wr,
  output logic                 wr_valid,
  input  wire logic            wr_ready,
  input  wire logic            link_clk,
  input  wire logic            spi_miso,
  output logic                 spi_sck,
  output logic                 spi_mosi,
  output logic                 spi_cs
);

  xsp_pkg::xsp_core_t s_reg;
  xsp_pkg::xsp_core_t s_next;
  logic               buf_ready;
  logic               rise;
  logic               fall;
  logic [5:0]         last_bit;
  logic               src_special;

  assign rise        = s_reg.lk[1] & ~s_reg.lk[2];
  assign fall        = ~s_reg.lk[1] & s_reg.lk[2];
  assign last_bit    = 6'({s_reg.nb, 3'b000}) - 6'h01;
  assign src_special = (s_reg.src == `XSP_SEL_ZERO) || (s_reg.src == `XSP_SEL_ONES);

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    logic        adv;
    logic [31:0] word;
    adv    = 1'b0;
    word   = '0;
    s_next = s_reg;
    s_next.lk    = {s_reg.lk[1:0], link_clk};
    s_next.mi    = {s_reg.mi[0], spi_miso};
    s_next.rd_en = 1'b0;
    // shift clock only runs out while bits move
    s_next.sck   = (s_reg.ph == xsp_pkg::XSP_SHIFT) ? s_reg.lk[1] : 1'b0;
    unique case (s_reg.ph)
      xsp_pkg::XSP_IDLE: begin
        if (cmd_valid) begin
          s_next.left = cmd.ops[15] ? 16'(-cmd.ops) : cmd.ops;
          s_next.inc  = cmd.ops[15];
          s_next.src  = cmd.src;
          s_next.dst  = cmd.dst;
          s_next.nb   = cmd.nbytes[2:0];
          s_next.hs   = (cmd.hs == `XSP_HS_ON);
          s_next.cnt  = 8'(`XSP_CS_PULSE_CYC);
          if (cmd.ops != 16'h0000) begin
            s_next.busy = 1'b1;
            // a command with chip select action 1 or 2 replays its chip select pulse
            if (cmd.cs_mode == `XSP_CS_FALL) begin
              s_next.cs = 1'b1;
              s_next.ph = xsp_pkg::XSP_CSP;
            end else if (cmd.cs_mode == `XSP_CS_RISE) begin
              s_next.cs = 1'b0;
              s_next.ph = xsp_pkg::XSP_CSP;
            end else begin
              s_next.ph = (cmd.hs == `XSP_HS_ON) ? xsp_pkg::XSP_HS : xsp_pkg::XSP_FETCH;
            end
          end
        end
      end
      xsp_pkg::XSP_CSP: begin
        s_next.cnt = s_reg.cnt - 8'h01;
        if (s_reg.cnt == 8'h01) begin
          s_next.cs = ~s_reg.cs;
          s_next.ph = s_reg.hs ? xsp_pkg::XSP_HS : xsp_pkg::XSP_FETCH;
        end
      end
      xsp_pkg::XSP_HS: begin
        if (!s_reg.mi[1]) begin
          s_next.ph = xsp_pkg::XSP_FETCH;
        end
      end
      xsp_pkg::XSP_FETCH: begin
        s_next.rd_en = !src_special;
        s_next.ph    = xsp_pkg::XSP_LOAD;
      end
      xsp_pkg::XSP_LOAD: begin
        if (s_reg.src == `XSP_SEL_ZERO) begin
          word = '0;
        end else if (s_reg.src == `XSP_SEL_ONES) begin
          word = '1;
        end else begin
          word = rd_data;
        end
        // right aligned data moves to the top so the msb leaves first
        s_next.sh   = word << (6'd32 - 6'({s_reg.nb, 3'b000}));
        s_next.rx   = '0;
        s_next.bits = '0;
        s_next.ph   = xsp_pkg::XSP_ALIGN;
      end
      xsp_pkg::XSP_ALIGN: begin
        s_next.mosi = s_reg.sh[31];
        if (fall) begin
          s_next.ph = xsp_pkg::XSP_SHIFT;
        end
      end
      xsp_pkg::XSP_SHIFT: begin
        if (rise) begin
          s_next.rx   = {s_reg.rx[30:0], s_reg.mi[1]};
          s_next.bits = s_reg.bits + 6'h01;
          if (s_reg.bits == last_bit) begin
            s_next.ph = xsp_pkg::XSP_STORE;
          end
        end
        if (fall) begin
          s_next.sh   = s_reg.sh << 1;
          s_next.mosi = s_reg.sh[30];
        end
      end
      xsp_pkg::XSP_STORE: begin
        // the last clock pulse ends here, so busy never drops under a high clock
        if (s_reg.dst == `XSP_SEL_ZERO) begin
          adv = 1'b1;
        end else begin
          // a stalled write port holds the engine here, nothing is dropped
          s_next.push = 1'b1;
          if (s_reg.push && buf_ready) begin
            s_next.push = 1'b0;
            adv         = 1'b1;
          end
        end
      end
    endcase
    if (adv) begin
      s_next.left = s_reg.left - 16'h0001;
      if (s_reg.inc) begin
        if (src_special) begin
          s_next.dst = s_reg.dst + 16'h0001;
        end else begin
          s_next.src = s_reg.src + 16'h0001;
        end
      end
      if (s_reg.left == 16'h0001) begin
        s_next.ph   = xsp_pkg::XSP_IDLE;
        s_next.busy = 1'b0;
      end else begin
        s_next.ph = s_reg.hs ? xsp_pkg::XSP_HS : xsp_pkg::XSP_FETCH;
      end
    end
    // ready kept as its own flop so the port needs no gate after the register
    s_next.rdy = !s_next.busy;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg    <= '0;
      s_reg.cs <= `XSP_CS_RESET;
      s_reg.rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------------
  // write path buffer
  // --------------------------------------------------------------------------
  xsp_skid2 #(.W($bits(xsp_pkg::xsp_wr_t))) u_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   ({s_reg.dst, s_reg.rx}),
    .in_valid  (s_reg.push),
    .in_ready  (buf_ready),
    .out_data  (wr),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  assign cmd_ready = s_reg.rdy;
  assign busy      = s_reg.busy;
  assign rd_en     = s_reg.rd_en;
  assign rd_idx    = s_reg.src;
  assign spi_sck   = s_reg.sck;
  assign spi_mosi  = s_reg.mosi;
  assign spi_cs    = s_reg.cs;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_start_cause: assert property ($rose(busy) |-> $past(cmd_valid))
    else $error("busy rose without a command");
  chk_left_step: assert property (s_reg.push && buf_ready && s_reg.left > 16'h0001
    |=> s_reg.left == $past(s_reg.left) - 16'h0001)
    else $error("cycle count did not step");
  chk_idx_step: assert property (s_reg.push && buf_ready && s_reg.inc && !src_special
    |=> s_reg.src == $past(s_reg.src) + 16'h0001)
    else $error("source index did not step");
  chk_zero_fill: assert property (s_reg.ph == xsp_pkg::XSP_LOAD
    && s_reg.src == `XSP_SEL_ZERO |=> s_reg.sh == '0)
    else $error("zero source sent data");
  chk_no_store: assert property (s_reg.push |-> s_reg.dst != `XSP_SEL_ZERO)
    else $error("write to discarded destination");
  chk_byte_count: assert property (s_reg.ph == xsp_pkg::XSP_SHIFT && rise
    && s_reg.bits == last_bit |=> s_reg.ph != xsp_pkg::XSP_SHIFT)
    else $error("shift did not end after byte count");
  chk_msb_first: assert property (s_reg.ph == xsp_pkg::XSP_ALIGN
    |=> spi_mosi == $past(s_reg.sh[31]))
    else $error("first bit is not the msb");
  chk_cs_pulse: assert property (s_reg.ph == xsp_pkg::XSP_CSP && s_reg.cnt == 8'h01
    |=> spi_cs != $past(spi_cs) && s_reg.ph != xsp_pkg::XSP_CSP)
    else $error("chip select pulse wrong");
  chk_hs_wait: assert property (s_reg.ph == xsp_pkg::XSP_HS && s_reg.mi[1]
    |=> s_reg.ph == xsp_pkg::XSP_HS)
    else $error("cycle started without handshake");
  chk_idle_quiet: assert property (!busy |-> !spi_sck ##1 !s_reg.push)
    else $error("activity while idle");

  cov_store: cover property (s_reg.push && buf_ready);
  cov_stall: cover property (s_reg.push && !buf_ready);
  cov_auto_inc: cover property (s_reg.inc && $fell(busy));
  cov_handshake: cover property (s_reg.ph == xsp_pkg::XSP_HS ##1 s_reg.ph == xsp_pkg::XSP_FETCH);

endmodule : xsp_engine

// file: xsp_spi_dev.sv
/*
  External device model on the far side of the serial port: takes mosi on the
  clock rise, shifts out its own byte stream on the fall.
  Assumes mode-0 timing and a ready input from the bench.
*/
`timescale 1ns/1ps
module xsp_spi_dev (
  input  wire logic spi_sck,
  input  wire logic spi_mosi,
  input  wire logic rdy_n,
  output logic      spi_miso,
  output logic      rx_tgl,
  output logic [7:0] rx_byte
);
  logic [7:0] k_reg    = 8'h00;
  logic [2:0] bit_reg  = 3'h0;
  logic [7:0] sh_reg   = 8'h00;
  logic       out_reg  = 1'b0;
  logic       tgl_reg  = 1'b0;
  logic [7:0] byte_reg = 8'h00;
  wire  [7:0] tx       = 8'h35 + k_reg;
  // line has a pull-up: high while not ready, the data bit from out_reg once ready
  assign spi_miso = rdy_n ? 1'b1 : out_reg;
  assign rx_tgl   = tgl_reg;
  assign rx_byte  = byte_reg;
  always @(posedge spi_sck) begin
    sh_reg  <= {sh_reg[6:0], spi_mosi};
    bit_reg <= bit_reg + 3'h1;
    if (bit_reg == 3'h7) begin
      byte_reg <= {sh_reg[6:0], spi_mosi};
      tgl_reg  <= ~tgl_reg;
      k_reg    <= k_reg + 8'h01;
    end
  end
  always @(negedge spi_sck) out_reg <= tx[3'h7 - bit_reg];
endmodule : xsp_spi_dev

// file: test_xsp_engine.sv
/*
  Self-checking bench of the serial port transfer engine: register file,
  stalling write side, link clock and a device model.
  Assumes the design files and xsp_spi_dev.sv are compiled first.
*/
`timescale 1ns/1ps
module test_xsp_engine;
  logic              core_clk  = 1'b0;
  logic              rst       = 1'b1;
  logic              link_clk  = 1'b0;
  logic              rdy_n     = 1'b0;
  logic              stall     = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              wr_ready  = 1'b0;
  logic              cs_lvl    = 1'b1;
  logic [31:0]       rd_data   = 32'h0;
  logic [31:0]       rnd       = 32'h662d;
  logic [31:0]       rnd_w     = 32'h662d;
  xsp_pkg::xsp_cmd_t cmd       = '0;
  xsp_pkg::xsp_wr_t  wr;
  logic              cmd_ready, busy, rd_en, wr_valid, spi_sck, spi_mosi, spi_cs;
  logic              spi_miso, rx_tgl;
  logic [15:0]       rd_idx;
  logic [7:0]        rx_byte;
  logic [31:0]       regs [256];
  logic [47:0]       exp_wr [$];
  logic [7:0]        exp_tx [$];
  int                err_total = 0;
  int                n_checks  = 0;
  int                n_sck     = 0;
  int                dev_k     = 0;
  int                csm_list [5] = '{1, 2, 0, 1, 2};

  always #4 core_clk = ~core_clk;
  initial begin
    #2.7;
    forever #80 link_clk = ~link_clk;
  end
  always @(posedge spi_sck) n_sck++;

  xsp_engine dut (.core_clk(core_clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .busy(busy), .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data),
    .wr(wr), .wr_valid(wr_valid), .wr_ready(wr_ready), .link_clk(link_clk),
    .spi_miso(spi_miso), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_cs(spi_cs));
  xsp_spi_dev dev (.spi_sck(spi_sck), .spi_mosi(spi_mosi), .rdy_n(rdy_n),
    .spi_miso(spi_miso), .rx_tgl(rx_tgl), .rx_byte(rx_byte));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [47:0] seen, input logic [47:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // register file with one-cycle read latency; write side stalls at random
  always @(posedge core_clk) begin
    #1;
    if (rd_en) rd_data = regs[rd_idx[7:0]];
    rnd_w = lfsr(rnd_w);
    wr_ready = !stall && rnd_w[3];
  end
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) chk(wr, exp_wr.size() ? exp_wr.pop_front() : 'x);
  end
  always @(rx_tgl) begin
    #1;
    if ($time > 1) chk(rx_byte, exp_tx.size() ? exp_tx.pop_front() : 'x);
  end

  // ------------------------------------------------------------------
  // one command: note expectations, issue, wait for completion
  // ------------------------------------------------------------------
  task automatic run(input int ops, src, dst, nb, csm, hs);
    int n, s, d, t, sck0;
    logic [31:0] w, r;
    n = ops < 0 ? -ops : ops;
    for (int c = 0; c < n; c++) begin
      s = src;
      d = dst;
      if (ops < 0 && (src == 0 || src == 16'hffff)) d = dst + c;
      else if (ops < 0) s = src + c;
      w = (src == 0) ? 32'h0 : (src == 16'hffff) ? 32'hffffffff : regs[s];
      r = 32'h0;
      for (int b = nb - 1; b >= 0; b--) begin
        exp_tx.push_back(w[8*b +: 8]);
        r = {r[23:0], 8'h35 + dev_k[7:0]};
        dev_k++;
      end
      if (d != 0) exp_wr.push_back({d[15:0], r});
    end
    sck0 = n_sck;
    @(posedge core_clk);
    #1;
    cmd = {ops[15:0], src[15:0], dst[15:0], nb[15:0], csm[15:0], hs[15:0]};
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    t = 0;
    while (busy !== 1'b1 && t < 9) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    repeat (5) @(posedge core_clk);
    if (csm == 1) chk(spi_cs, 1'b1);
    if (csm == 2) chk(spi_cs, 1'b0);
    if (csm != 0) cs_lvl = (csm == 2);
    t = 0;
    while (busy !== 1'b0 && t < 6000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    chk(busy, 1'b0);
    chk(spi_cs, cs_lvl);
    chk(n_sck - sck0, 8 * nb * n);
    $display("test done: ops %0d src %0d dst %0d bytes %0d", ops, src, dst, nb);
  endtask : run

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      rnd = lfsr(rnd);
      regs[i] = rnd;
    end
    repeat (20) @(posedge core_clk);
    chk({cmd_ready, busy, rd_en, wr_valid, spi_sck, spi_mosi, spi_cs}, 7'b1000001);
    #1;
    rst = 1'b0;
    rdy_n = 1'b1;
    fork
      begin
        repeat (400) @(posedge core_clk);
        chk(n_sck, 0);
        #1;
        rdy_n = 1'b0;
      end
    join_none
    run(2, 20, 101, 1, 0, 1);
    foreach (csm_list[i]) run(1, 16'hffff, 0, 1, csm_list[i], 0);
    // zero count: taken but starts nothing
    run(0, 20, 101, 1, 0, 0);
    run(-3, 11, 120, 4, 0, 0);
    run(-2, 0, 130, 2, 0, 0);
    run(3, 16'hffff, 0, 3, 0, 0);
    for (int n = 1; n <= 4; n++) run(1, 30 + n, 140 + n, n, 0, 0);
    stall = 1'b1;
    fork
      run(4, 40, 150, 1, 0, 0);
      begin
        // two words buffered, third held back by the engine
        repeat (1200) @(posedge core_clk);
        chk({busy, wr_valid}, 2'b11);
        stall = 1'b0;
      end
    join
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      run(rnd[0] ? -(rnd[2:1] + 1) : rnd[2:1] + 1, 11 + rnd[9:4], 160 + 4 * i,
          rnd[11:10] + 1, 0, 0);
    end
    repeat (50) @(posedge core_clk);
    chk(exp_wr.size() + exp_tx.size(), 0);
    results();
  end

  // watchdog at several times the expected run length
  initial begin
    #400_000;
    err_total++;
    results();
  end
endmodule : test_xsp_engine
